// ### dv/fwsr_host.sv
// host read-strobe model for status polling
`timescale 1ns/1ps
module fwsr_host (
  // clock and mode
  input wire core_clk_in,
  input wire sync_mode_in,
  // read strobes
  output reg output_enable_n_out = 1'b1,
  output reg chip_select_n_out = 1'b1,
  output reg address_valid_n_out = 1'b1
);
  // strobes move on falling edges only; wait covers the 2-stage synchroniser
  task read_cycle;
  begin
    @(negedge core_clk_in);
    chip_select_n_out = 1'b0;
    if (sync_mode_in)
      address_valid_n_out = 1'b0;
    else
      output_enable_n_out = 1'b0;
    repeat (2) @(negedge core_clk_in);
    {output_enable_n_out, chip_select_n_out, address_valid_n_out} = 3'h7;
    repeat (6) @(negedge core_clk_in);
  end
  endtask
endmodule // fwsr_host

// ### dv/fwsr_status_props.sv
// concurrent checks on the write status reporter ports
`timescale 1ns/1ps
module fwsr_status_props (
  // clock, reset, strobes and qualifiers
  input wire core_clk_in, rst_in, output_enable_n_in, chip_select_n_in, address_valid_n_in,
  input wire sync_mode_in, addr_in_erase_sector_in, addr_in_prog_bank_in, addr_in_suspended_sector_in,
  input wire [7:0] array_data_in,
  // commands and algorithm feedback
  input wire cmd_program_in, cmd_sector_erase_in, cmd_chip_erase_in, cmd_erase_suspend_in,
  input wire cmd_erase_resume_in, cmd_reset_in, algo_pulse_in, algo_done_in, prog_one_over_zero_in,
  input wire [7:0] cmd_program_data_in,
  // status
  input wire [7:0] low_status_byte_out,
  input wire erase_window_flag_out, cmd_rejected_out, ready_busy_n_pin_out, ready_busy_n_pin_oe_out
);
  default clocking
    @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  AST_RESET_STATE: assert property (disable iff (1'b0) rst_in |=>
    low_status_byte_out == 8'hFF && !ready_busy_n_pin_oe_out) else $error("reset state wrong");
  AST_PIN_LOW: assert property (ready_busy_n_pin_out == 1'b0)
    else $error("busy pin drives high");
  AST_WINDOW_BUSY: assert property ($rose(erase_window_flag_out) |-> ##[0:2] ready_busy_n_pin_oe_out)
    else $error("erasing but pin released");
  AST_WINDOW_BITS: assert property (erase_window_flag_out && $past(erase_window_flag_out)
    && ready_busy_n_pin_oe_out && $past(ready_busy_n_pin_oe_out) && addr_in_erase_sector_in
    && $past(addr_in_erase_sector_in) && !$past(addr_in_prog_bank_in)
    |-> low_status_byte_out[3] && !low_status_byte_out[7]) else $error("erase status bits wrong");
  AST_REJECT_CAUSE: assert property (cmd_rejected_out |-> $past(cmd_program_in | cmd_sector_erase_in
    | cmd_chip_erase_in | cmd_erase_suspend_in | cmd_erase_resume_in | cmd_reset_in))
    else $error("reject without command");
  AST_REJECT_PROG: assert property (erase_window_flag_out && ready_busy_n_pin_oe_out
    && cmd_program_in ##1 erase_window_flag_out |-> cmd_rejected_out)
    else $error("program accepted while erasing");
  AST_DONE_READY: assert property (algo_done_in && erase_window_flag_out && ready_busy_n_pin_oe_out
    && !prog_one_over_zero_in |-> ##[1:2] !ready_busy_n_pin_oe_out) else $error("pin busy after done");
  AST_IDLE_DATA: assert property (!$past(rst_in) && !ready_busy_n_pin_oe_out
    && !$past(ready_busy_n_pin_oe_out) && !$past(addr_in_suspended_sector_in)
    |-> low_status_byte_out == $past(array_data_in)) else $error("ready but no array data");
endmodule // fwsr_status_props

bind fwsr_status fwsr_status_props props_u (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .output_enable_n_in(output_enable_n_in), .chip_select_n_in(chip_select_n_in),
  .address_valid_n_in(address_valid_n_in), .sync_mode_in(sync_mode_in),
  .addr_in_erase_sector_in(addr_in_erase_sector_in), .addr_in_prog_bank_in(addr_in_prog_bank_in),
  .addr_in_suspended_sector_in(addr_in_suspended_sector_in), .array_data_in(array_data_in),
  .cmd_program_in(cmd_program_in), .cmd_sector_erase_in(cmd_sector_erase_in),
  .cmd_chip_erase_in(cmd_chip_erase_in), .cmd_erase_suspend_in(cmd_erase_suspend_in),
  .cmd_erase_resume_in(cmd_erase_resume_in), .cmd_reset_in(cmd_reset_in), .algo_pulse_in(algo_pulse_in),
  .algo_done_in(algo_done_in), .prog_one_over_zero_in(prog_one_over_zero_in),
  .cmd_program_data_in(cmd_program_data_in), .low_status_byte_out(low_status_byte_out),
  .erase_window_flag_out(erase_window_flag_out), .cmd_rejected_out(cmd_rejected_out),
  .ready_busy_n_pin_out(ready_busy_n_pin_out), .ready_busy_n_pin_oe_out(ready_busy_n_pin_oe_out));

// ### dv/fwsr_status_test.sv
// self-checking bench for the write status reporter
`timescale 1ns/1ps
module fwsr_status_test;
  reg clk = 0, rst = 1, sync_m = 0, in_es = 1, in_pb = 0, in_ss = 0, algo_p = 0, done = 0, ovz = 0;
  reg prog = 0, serase = 0, cerase = 0, susp = 0, resume = 0, rstc = 0;
  // reference toggle state, flipped by the rules on every read
  reg [7:0] arr = 8'h00, pdata = 8'h00, mdl_toggle = 8'h00;
  wire oe_n, ce_n, adv_n, rej, wflag, pin, pin_oe;
  wire [7:0] st;
  integer seed = 32'h6C68, errors = 0, samples_checked = 0, i;
  ////////////////////////////////////////////////////////////////
  fwsr_status #(.WINDOW_CYCLES(20), .RESET_CYCLES(4), .PULSE_LIMIT(8)) dut_u (.core_clk_in(clk),
    .rst_in(rst), .output_enable_n_in(oe_n), .chip_select_n_in(ce_n), .address_valid_n_in(adv_n),
    .sync_mode_in(sync_m), .addr_in_erase_sector_in(in_es), .addr_in_prog_bank_in(in_pb),
    .addr_in_suspended_sector_in(in_ss), .array_data_in(arr), .cmd_program_in(prog),
    .cmd_program_data_in(pdata), .cmd_sector_erase_in(serase), .cmd_chip_erase_in(cerase),
    .cmd_erase_suspend_in(susp), .cmd_erase_resume_in(resume), .cmd_reset_in(rstc),
    .algo_pulse_in(algo_p), .algo_done_in(done), .prog_one_over_zero_in(ovz),
    .low_status_byte_out(st), .erase_window_flag_out(wflag), .cmd_rejected_out(rej),
    .ready_busy_n_pin_out(pin), .ready_busy_n_pin_oe_out(pin_oe));
  fwsr_host host_u (.core_clk_in(clk), .sync_mode_in(sync_m), .output_enable_n_out(oe_n),
    .chip_select_n_out(ce_n), .address_valid_n_out(adv_n));
  initial
    forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////
  task chk(input string n, input [7:0] e, input [7:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // k: 0 program, 1 sector erase, 2 chip erase, 3 suspend, 4 resume, 5 reset
  task cmd(input integer k);
  begin
    @(negedge clk);
    {rstc, resume, susp, cerase, serase, prog} = 6'h01 << k;
    @(negedge clk);
    {rstc, resume, susp, cerase, serase, prog} = 6'h00;
  end
  endtask
  // m marks the toggle bits that must flip on each of two reads
  task rd2(input [7:0] m);
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      host_u.read_cycle();
      mdl_toggle = mdl_toggle ^ m;
      chk("toggles", mdl_toggle & 8'h44, st & 8'h44);
    end
  end
  endtask
  task fin;
  begin
    arr = $random(seed);
    done = 1;
    wt(1);
    done = 0;
    wt(3);
    chk("array after done", arr, st);
    chk("pin after done", 8'h00, {7'h0, pin_oe});
    chk("pin level", 8'h00, {7'h0, pin});
  end
  endtask
  task report_and_stop;
  begin
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    wt(11);
    chk("reset", 8'hFE, {st[7:1], pin_oe});
    wt(1);
    rst = 0;
    arr = $random(seed);
    wt(3);
    chk("idle data", arr, st);
    cmd(1);
    wt(2);
    chk("erase start", 8'h01, {st[7], st[3], 5'h0, pin_oe});
    wt(10);
    cmd(1);
    wt(17);
    chk("window restart", 8'h00, {7'h0, wflag});
    wt(6);
    chk("window closed", 8'h03, {6'h0, st[3], wflag});
    rd2(8'h44);
    cmd(0);
    chk("reject", 8'h01, {7'h0, rej});
    fin();
    cmd(2);
    wt(3);
    chk("chip erase", 8'h03, {6'h0, wflag, pin_oe});
    fin();
    $display("erase tests done");
    in_pb = 1;
    pdata = $random(seed);
    cmd(0);
    wt(2);
    chk("program poll", {~pdata[7], 7'h0}, st & 8'hA0);
    rd2(8'h40);
    ovz = 1;
    for (i = 0; i < 20; i = i + 1)
    begin
      algo_p = ~algo_p;
      wt(1);
    end
    wt(3);
    chk("timeout flag", 8'h20, st & 8'h20);
    rd2(8'h40);
    ovz = 0;
    cmd(5);
    for (i = 0; i < 50 && pin_oe !== 1'b0; i = i + 1)
      wt(1);
    if (pin_oe !== 1'b0)
    begin
      errors = errors + 1;
      report_and_stop();
    end
    $display("program tests done");
    in_pb = 0;
    cmd(1);
    wt(24);
    cmd(3);
    in_ss = 1;
    wt(3);
    chk("suspend ready", 8'h00, {7'h0, pin_oe});
    rd2(8'h04);
    sync_m = 1;
    rd2(8'h04);
    {in_ss, in_es, sync_m} = 3'h0;
    arr = $random(seed);
    wt(3);
    chk("outside data", arr, st);
    in_pb = 1;
    pdata = $random(seed);
    cmd(0);
    wt(2);
    chk("suspend program", {~pdata[7], 6'h0, 1'b1}, {st[7], 6'h0, pin_oe});
    done = 1;
    wt(1);
    {done, in_pb} = 2'h0;
    wt(3);
    chk("suspend program done", 8'h00, {7'h0, pin_oe});
    cmd(4);
    wt(2);
    chk("resumed", 8'h01, {7'h0, pin_oe});
    in_es = 1;
    rd2(8'h44);
    fin();
    $display("suspend tests done");
    report_and_stop();
  end
endmodule // fwsr_status_test

// ### hdl/fwsr_regs.vh
// timing counts and status bit positions for the write status reporter
`ifndef FWSR_REGS_VH
`define FWSR_REGS_VH
`define FWSR_CLK_MHZ 40
`define FWSR_WINDOW_US 50
`define FWSR_WINDOW_CYCLES (`FWSR_WINDOW_US * `FWSR_CLK_MHZ)
`define FWSR_RESET_CYCLES 40
`define FWSR_PULSE_LIMIT 1000
`define FWSR_BIT_SECTOR_TOGGLE 2
`define FWSR_BIT_ERASE_WINDOW 3
`define FWSR_BIT_TIMEOUT_FAIL 5
`define FWSR_BIT_BUSY_TOGGLE 6
`define FWSR_BIT_DATA_POLL 7
`define FWSR_MODE_IDLE 3'h0
`define FWSR_MODE_PROGRAM 3'h1
`define FWSR_MODE_ERASE 3'h2
`define FWSR_MODE_SUSPEND 3'h3
`define FWSR_MODE_SUSP_PROG 3'h4
`define FWSR_MODE_FAILED 3'h5
`define FWSR_MODE_RESETTING 3'h6
`endif

// ### hdl/fwsr_status.v
// write status reporter: builds the status byte and ready/busy pin for program and erase
`timescale 1ns/1ps
`include "fwsr_regs.vh"

// Operation
// - sector toggle flag flips on consecutive reads inside erase-selected sectors.
// - sector toggle status valid from the final write strobe rising edge.
// - read cycles end on output enable or chip select, or address valid.
// - after completion toggles stop and the next read returns array data.
// - timeout flag goes high when the pulse-count limit is reached.
// - programming one over zero halts; timeout flag then rises; erase restores ones.
// - erase window flag low during window, high after; added erases restart it.
// - with window flag high only erase suspend is accepted.
// - busy toggle flips while erasing, stops in suspend, sector-blind.
// - inverted poll and sector toggle meaningful only at valid addresses.
// - during program, reads of the bank show inverted last written bit.
// - busy toggle flips on consecutive reads anywhere during an algorithm.
// - ready/busy pin pulled low during program, erase or reset.
// - inverted poll flag reads zero during erase, one after.
module fwsr_status #(
  parameter WINDOW_CYCLES = `FWSR_WINDOW_CYCLES,
  parameter RESET_CYCLES = `FWSR_RESET_CYCLES,
  parameter PULSE_LIMIT = `FWSR_PULSE_LIMIT
) (
  // clock and reset
  input wire core_clk_in,
  input wire rst_in,
  // host read strobes (pins, synchronised here)
  input wire output_enable_n_in,
  input wire chip_select_n_in,
  input wire address_valid_n_in,
  input wire sync_mode_in,
  // address qualifiers from the array decoder
  input wire addr_in_erase_sector_in,
  input wire addr_in_prog_bank_in,
  input wire addr_in_suspended_sector_in,
  input wire [7:0] array_data_in,
  // command decoder events, one-cycle pulses after the final write strobe edge
  input wire cmd_program_in,
  input wire [7:0] cmd_program_data_in,
  input wire cmd_sector_erase_in,
  input wire cmd_chip_erase_in,
  input wire cmd_erase_suspend_in,
  input wire cmd_erase_resume_in,
  input wire cmd_reset_in,
  // embedded algorithm feedback
  input wire algo_pulse_in,
  input wire algo_done_in,
  input wire prog_one_over_zero_in,
  // status outputs
  output reg [7:0] low_status_byte_out,
  output reg erase_window_flag_out,
  output reg cmd_rejected_out,
  output reg ready_busy_n_pin_out,
  output reg ready_busy_n_pin_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  reg [1:0] oe_sync, ce_sync, av_sync;
  reg strobe_prev;
  reg [2:0] mode, resume_mode;
  reg busy_toggle_flag, sector_toggle_flag, timeout_fail_flag;
  reg [7:0] last_data;
  reg [31:0] window_cnt, pulse_cnt, reset_cnt;
  reg in_window;
  reg halted;
  wire strobe_now;
  wire read_end;
  wire algo_active;
  wire cmd_any;
  wire accept_erase_add;
  reg [7:0] next_status;

  // read cycle closes on strobe rising edge; strobe_prev holds the old level
  assign strobe_now = sync_mode_in ? av_sync[1] : (oe_sync[1] | ce_sync[1]);
  assign read_end = strobe_now & ~strobe_prev;

  assign algo_active = (mode == `FWSR_MODE_PROGRAM) || (mode == `FWSR_MODE_ERASE) ||
                       (mode == `FWSR_MODE_SUSP_PROG) || (mode == `FWSR_MODE_FAILED);
  assign cmd_any = cmd_program_in | cmd_sector_erase_in | cmd_chip_erase_in | cmd_erase_resume_in;
  // added sector erases only while the window is still open
  assign accept_erase_add = (mode == `FWSR_MODE_ERASE) && in_window && cmd_sector_erase_in;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      oe_sync <= 2'h3;
      ce_sync <= 2'h3;
      av_sync <= 2'h3;
      strobe_prev <= 1'b1;
    end
    else
    begin
      oe_sync <= {oe_sync[0], output_enable_n_in};
      ce_sync <= {ce_sync[0], chip_select_n_in};
      av_sync <= {av_sync[0], address_valid_n_in};
      strobe_prev <= strobe_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      mode <= `FWSR_MODE_IDLE;
      resume_mode <= `FWSR_MODE_IDLE;
      last_data <= 8'hFF;
      window_cnt <= 32'h0;
      in_window <= 1'b0;
      pulse_cnt <= 32'h0;
      reset_cnt <= 32'h0;
      timeout_fail_flag <= 1'b0;
      halted <= 1'b0;
      cmd_rejected_out <= 1'b0;
    end
    else
    begin
      cmd_rejected_out <= 1'b0;
      if (in_window)
      begin
        if (window_cnt >= WINDOW_CYCLES - 1)
          in_window <= 1'b0;
        else
          window_cnt <= window_cnt + 32'h1;
      end
      if (algo_pulse_in && (mode == `FWSR_MODE_PROGRAM || mode == `FWSR_MODE_ERASE ||
          mode == `FWSR_MODE_SUSP_PROG) && !in_window)
        pulse_cnt <= pulse_cnt + 32'h1;
      case (mode)
        `FWSR_MODE_IDLE:
        begin
          if (cmd_program_in)
          begin
            mode <= `FWSR_MODE_PROGRAM;
            last_data <= cmd_program_data_in;
            pulse_cnt <= 32'h0;
            halted <= prog_one_over_zero_in;
          end
          else if (cmd_sector_erase_in)
          begin
            mode <= `FWSR_MODE_ERASE;
            in_window <= 1'b1;
            window_cnt <= 32'h0;
            pulse_cnt <= 32'h0;
          end
          else if (cmd_chip_erase_in)
          begin
            mode <= `FWSR_MODE_ERASE;
            in_window <= 1'b0;
            pulse_cnt <= 32'h0;
          end
          else if (cmd_reset_in)
          begin
            mode <= `FWSR_MODE_RESETTING;
            reset_cnt <= 32'h0;
          end
        end
        `FWSR_MODE_PROGRAM, `FWSR_MODE_SUSP_PROG, `FWSR_MODE_ERASE:
        begin
          if (prog_one_over_zero_in && mode != `FWSR_MODE_ERASE)
            halted <= 1'b1;
          if (accept_erase_add)
          begin
            window_cnt <= 32'h0;
          end
          else if (cmd_erase_suspend_in && mode == `FWSR_MODE_ERASE && !in_window)
            mode <= `FWSR_MODE_SUSPEND;
          else if (cmd_reset_in && in_window)
          begin
            mode <= `FWSR_MODE_RESETTING;
            in_window <= 1'b0;
            reset_cnt <= 32'h0;
          end
          else if (cmd_any)
            cmd_rejected_out <= 1'b1;
          else if (pulse_cnt >= PULSE_LIMIT)
          begin
            mode <= `FWSR_MODE_FAILED;
            // remembers which algorithm failed for the poll bit
            resume_mode <= mode;
          end
          else if (algo_done_in && !halted && !in_window)
            mode <= (mode == `FWSR_MODE_SUSP_PROG) ? `FWSR_MODE_SUSPEND : `FWSR_MODE_IDLE;
        end
        `FWSR_MODE_SUSPEND:
        begin
          if (cmd_erase_resume_in)
            mode <= `FWSR_MODE_ERASE;
          else if (cmd_program_in)
          begin
            mode <= `FWSR_MODE_SUSP_PROG;
            last_data <= cmd_program_data_in;
            pulse_cnt <= 32'h0;
            halted <= prog_one_over_zero_in;
          end
          else if (cmd_reset_in)
          begin
            mode <= `FWSR_MODE_RESETTING;
            reset_cnt <= 32'h0;
          end
        end
        `FWSR_MODE_FAILED:
        begin
          timeout_fail_flag <= 1'b1;
          if (cmd_reset_in)
          begin
            mode <= `FWSR_MODE_RESETTING;
            reset_cnt <= 32'h0;
          end
        end
        `FWSR_MODE_RESETTING:
        begin
          timeout_fail_flag <= 1'b0;
          halted <= 1'b0;
          if (reset_cnt >= RESET_CYCLES - 1)
            mode <= `FWSR_MODE_IDLE;
          else
            reset_cnt <= reset_cnt + 32'h1;
        end
        default:
          mode <= `FWSR_MODE_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggles advance only at the end of a host read, never on their own
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      busy_toggle_flag <= 1'b0;
      sector_toggle_flag <= 1'b0;
    end
    else if (read_end)
    begin
      if (algo_active)
        busy_toggle_flag <= ~busy_toggle_flag;
      if ((mode == `FWSR_MODE_ERASE || mode == `FWSR_MODE_SUSPEND) && addr_in_erase_sector_in)
        sector_toggle_flag <= ~sector_toggle_flag;
    end
  end

  always @*
  begin
    next_status = array_data_in;
    case (mode)
      `FWSR_MODE_PROGRAM, `FWSR_MODE_SUSP_PROG:
      begin
        if (addr_in_prog_bank_in)
        begin
          next_status = 8'h00;
          next_status[`FWSR_BIT_DATA_POLL] = ~last_data[7];
          next_status[`FWSR_BIT_BUSY_TOGGLE] = busy_toggle_flag;
        end
      end
      `FWSR_MODE_ERASE, `FWSR_MODE_FAILED:
      begin
        next_status = 8'h00;
        next_status[`FWSR_BIT_DATA_POLL] = 1'b0;
        next_status[`FWSR_BIT_BUSY_TOGGLE] = busy_toggle_flag;
        next_status[`FWSR_BIT_TIMEOUT_FAIL] = timeout_fail_flag;
        next_status[`FWSR_BIT_ERASE_WINDOW] = ~in_window;
        next_status[`FWSR_BIT_SECTOR_TOGGLE] = sector_toggle_flag;
        if (mode == `FWSR_MODE_FAILED && resume_mode != `FWSR_MODE_ERASE)
          next_status[`FWSR_BIT_DATA_POLL] = ~last_data[7];
      end
      `FWSR_MODE_SUSPEND:
      begin
        if (addr_in_suspended_sector_in)
        begin
          next_status = 8'h00;
          next_status[`FWSR_BIT_DATA_POLL] = 1'b1;
          next_status[`FWSR_BIT_BUSY_TOGGLE] = busy_toggle_flag;
          next_status[`FWSR_BIT_SECTOR_TOGGLE] = sector_toggle_flag;
        end
        // else array data
      end
      default:
        next_status = array_data_in;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_in)
  begin
    if (rst_in)
    begin
      low_status_byte_out <= 8'hFF;
      erase_window_flag_out <= 1'b0;
      ready_busy_n_pin_out <= 1'b0;
      ready_busy_n_pin_oe_out <= 1'b0;
    end
    else
    begin
      low_status_byte_out <= next_status;
      erase_window_flag_out <= (mode == `FWSR_MODE_ERASE) & ~in_window;
      ready_busy_n_pin_out <= 1'b0;
      // open drain: only ever pulls low
      ready_busy_n_pin_oe_out <= (mode != `FWSR_MODE_IDLE) && (mode != `FWSR_MODE_SUSPEND);
    end
  end

endmodule // fwsr_status
